// ### rtl/fpd_button.v
// button synchroniser and press edge detector
`timescale 1ns/1ps
module fpd_button (
	input wire clk_i,
	input wire rst_n_i,
	input wire btn_i,
	output wire press_o
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	// two-stage synchroniser then edge detect on stages two and three
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= btn_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	assign press_o = s2_reg & ~s3_reg;
endmodule // fpd_button

// ### rtl/fpd_defs.vh
// constants for the front panel status display
`ifndef FPD_DEFS_VH
`define FPD_DEFS_VH
`define FPD_PAGE_OPER 5'h01
`define FPD_PAGE_ERR 5'h02
`define FPD_PAGE_IO 5'h04
`define FPD_PAGE_LINK 5'h08
`define FPD_PAGE_LIB 5'h10
`define FPD_HIST_DEPTH 8
`define FPD_CLK_HZ 125000000
`define FPD_ANIM_MS 250
`define FPD_ANIM_CYC ((`FPD_CLK_HZ / 1000) * `FPD_ANIM_MS)
`define FPD_CH_SP 8'h20
`define FPD_CH_W 8'h57
`define FPD_CH_H 8'h48
`define FPD_CH_G 8'h47
`define FPD_CH_1 8'h31
`define FPD_CH_2 8'h32
`define FPD_CH_3 8'h33
`define FPD_CH_M 8'h4D
`define FPD_CH_O 8'h4F
`define FPD_CH_D 8'h44
`define FPD_CH_E 8'h45
`define FPD_CH_R 8'h52
`define FPD_CH_A 8'h41
`define FPD_CH_L 8'h4C
`define FPD_CH_DASH 8'h2D
`define FPD_CH_UND 8'h5F
`define FPD_SL_ERR_RUN 8'h07
`define FPD_SL_ERR_START 8'h08
`define FPD_FB_UNSUP 8'hD2
`define FPD_FB_COLLATE 8'hD6
`define FPD_FB_XFER 8'hD9
`define FPD_FB_PWR 8'hE0
`define FPD_FB_TXTO 8'hE2
`define FPD_FB_DUPADDR 8'hF0
`define FPD_FB_BUSOFF 8'hF1
`define FPD_FB_SWITCH 8'hF3
`define FPD_FB_WDOG 8'hF6
`define FPD_FB_NVMEM 8'hF8
`define FPD_FB_RAM 8'hF9
`define FPD_LIB_CALL_ERR 8'h7C
`define FPD_CAP_32KW 8'h20
`endif

// ### rtl/fpd_display.v
// front panel status display controller
`timescale 1ns/1ps
`include "fpd_defs.vh"
module fpd_display #(
	parameter ANIM_CYC = `FPD_ANIM_CYC
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire mode_btn_i,
	input wire inc_btn_i,
	input wire legacy_mode_i,
	input wire prog_run_i,
	input wire fault_err_i,
	input wire fault_alarm_i,
	input wire [7:0] fault_code_i,
	input wire flash_busy_i,
	input wire hist_we_i,
	input wire [7:0] hist_code_i,
	input wire [7:0] hist_msg_i,
	input wire [15:0] hist_detail_i,
	input wire [15:0] hist_time_i,
	input wire [63:0] io_bits_i,
	input wire [2:0] serial_active_i,
	input wire serial_run_fault_i,
	input wire serial_start_fault_i,
	input wire fb_active_i,
	input wire [5:0] fb_node_addr_i,
	input wire [10:0] fb_fault_i,
	input wire tool_high_speed_i,
	input wire [2:0] lib_mounted_i,
	input wire [2:0] lib_enabled_i,
	input wire [2:0] lib_called_i,
	input wire [7:0] lib_id_i,
	input wire [15:0] lib_ver_i,
	input wire [7:0] p2_cap_kw_i,
	input wire [7:0] p3_cap_kw_i,
	output reg [4:0] page_o,
	output reg [1:0] sub_view_o,
	output reg [2:0] hist_sel_o,
	output reg [1:0] lib_sel_o,
	output reg [63:0] text_o,
	output reg [63:0] bits_o,
	output reg [7:0] seg8_o,
	output reg [6:0] lib_glyph_o,
	output reg lib_err_o,
	output reg [2:0] lib_disabled_o
);
	localparam AW = 32;
	wire mode_press;
	wire inc_press;
	reg [4:0] page_next;
	reg [AW-1:0] anim_cnt_reg;
	reg anim_tick_reg;
	reg [2:0] anim_ph_reg;
	reg blink_reg;
	reg [7:0] hist_code_mem [0:`FPD_HIST_DEPTH-1];
	reg [7:0] hist_msg_mem [0:`FPD_HIST_DEPTH-1];
	reg [15:0] hist_det_mem [0:`FPD_HIST_DEPTH-1];
	reg [15:0] hist_time_mem [0:`FPD_HIST_DEPTH-1];
	reg [2:0] hist_wp_reg;
	reg [7:0] fb_code;
	reg [7:0] sl_code;
	reg [63:0] text_next;
	reg [63:0] bits_next;
	reg [7:0] seg8_next;
	reg [6:0] glyph_next;
	reg [2:0] hidx;
	reg [2:0] lib_dis;
	reg lib_cap_err;
	reg [15:0] view_word;
	integer i;

	// one hex digit as its display character
	function [7:0] hex_ch;
		input [3:0] n;
		begin
			hex_ch = (n < 4'hA) ? {4'h3, n} : 8'h37 + {4'h0, n};
		end
	endfunction

	// a byte as two display characters, high digit first
	function [15:0] hex_pair;
		input [7:0] v;
		begin
			hex_pair = {hex_ch(v[7:4]), hex_ch(v[3:0])};
		end
	endfunction

	fpd_button u_mode (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.btn_i(mode_btn_i),
		.press_o(mode_press)
	);
	fpd_button u_inc (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.btn_i(inc_btn_i),
		.press_o(inc_press)
	);

	// page ring order
	always @* begin
		case (page_o)
			`FPD_PAGE_OPER: page_next = `FPD_PAGE_ERR;
			`FPD_PAGE_ERR: page_next = `FPD_PAGE_IO;
			`FPD_PAGE_IO: page_next = `FPD_PAGE_LINK;
			`FPD_PAGE_LINK: page_next = `FPD_PAGE_LIB;
			default: page_next = `FPD_PAGE_OPER;
		endcase
	end

	// button handling; a press of both at once is the chord on the error page
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			page_o <= `FPD_PAGE_OPER;
			sub_view_o <= 2'h0;
			hist_sel_o <= 3'h0;
			lib_sel_o <= 2'h0;
		end else begin
			if (page_o == `FPD_PAGE_ERR && inc_btn_i && mode_press) begin
				sub_view_o <= (sub_view_o == 2'h2) ? 2'h0 : sub_view_o + 2'h1;
			end else if (page_o == `FPD_PAGE_ERR && mode_btn_i && inc_press) begin
				sub_view_o <= (sub_view_o == 2'h2) ? 2'h0 : sub_view_o + 2'h1;
			end else if (mode_press && !inc_btn_i) begin
				page_o <= page_next;
				sub_view_o <= 2'h0;
			end else if (inc_press && !mode_btn_i) begin
				case (page_o)
					`FPD_PAGE_ERR: hist_sel_o <= hist_sel_o + 3'h1;
					`FPD_PAGE_IO: begin
						sub_view_o <= (sub_view_o == 2'h2) ? 2'h0 : sub_view_o + 2'h1;
					end
					`FPD_PAGE_LIB: begin
						lib_sel_o <= (lib_sel_o == 2'h2) ? 2'h0 : lib_sel_o + 2'h1;
					end
					default: lib_sel_o <= lib_sel_o;
				endcase
			end
		end
	end

	// animation and blink rate divider
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			anim_cnt_reg <= {AW{1'b0}};
			anim_tick_reg <= 1'b0;
			anim_ph_reg <= 3'h0;
			blink_reg <= 1'b0;
		end else begin
			anim_tick_reg <= 1'b0;
			if (anim_cnt_reg == ANIM_CYC - 1) begin
				anim_cnt_reg <= {AW{1'b0}};
				anim_tick_reg <= 1'b1;
			end else begin
				anim_cnt_reg <= anim_cnt_reg + 1'b1;
			end
			if (anim_tick_reg) begin
				anim_ph_reg <= anim_ph_reg + 3'h1;
				blink_reg <= ~blink_reg;
			end
		end
	end

	// error history ring, newest entry written at the write pointer
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hist_wp_reg <= 3'h0;
			for (i = 0; i < `FPD_HIST_DEPTH; i = i + 1) begin
				hist_code_mem[i] <= 8'h00;
				hist_msg_mem[i] <= 8'h00;
				hist_det_mem[i] <= 16'h0000;
				hist_time_mem[i] <= 16'h0000;
			end
		end else if (hist_we_i) begin
			hist_code_mem[hist_wp_reg] <= hist_code_i;
			hist_msg_mem[hist_wp_reg] <= hist_msg_i;
			hist_det_mem[hist_wp_reg] <= hist_detail_i;
			hist_time_mem[hist_wp_reg] <= hist_time_i;
			hist_wp_reg <= hist_wp_reg + 3'h1;
		end
	end

	// fieldbus and serial error code priority
	always @* begin
		fb_code = 8'h00;
		if (fb_fault_i[0]) fb_code = `FPD_FB_UNSUP;
		else if (fb_fault_i[1]) fb_code = `FPD_FB_COLLATE;
		else if (fb_fault_i[2]) fb_code = `FPD_FB_XFER;
		else if (fb_fault_i[3]) fb_code = `FPD_FB_PWR;
		else if (fb_fault_i[4]) fb_code = `FPD_FB_TXTO;
		else if (fb_fault_i[5]) fb_code = `FPD_FB_DUPADDR;
		else if (fb_fault_i[6]) fb_code = `FPD_FB_BUSOFF;
		else if (fb_fault_i[7]) fb_code = `FPD_FB_SWITCH;
		else if (fb_fault_i[8]) fb_code = `FPD_FB_WDOG;
		else if (fb_fault_i[9]) fb_code = `FPD_FB_NVMEM;
		else if (fb_fault_i[10]) fb_code = `FPD_FB_RAM;
		sl_code = 8'h00;
		if (serial_start_fault_i) sl_code = `FPD_SL_ERR_START;
		else if (serial_run_fault_i) sl_code = `FPD_SL_ERR_RUN;
	end

	// library status
	always @* begin
		lib_dis = lib_called_i & ~lib_enabled_i;
		lib_cap_err = ((p2_cap_kw_i >= `FPD_CAP_32KW) && lib_enabled_i[2]) ||
			((p3_cap_kw_i >= `FPD_CAP_32KW) && lib_enabled_i[1]);
		// one segment per library, one per pair and one for all three keeps all seven distinct
		glyph_next = {lib_mounted_i == 3'h7, lib_mounted_i[2] & lib_mounted_i[1],
			lib_mounted_i[1] & lib_mounted_i[0], lib_mounted_i[2] & lib_mounted_i[0],
			lib_mounted_i};
	end

	// page content composition
	always @* begin
		hidx = hist_sel_o;
		view_word = 16'h0000;
		text_next = {8{`FPD_CH_SP}};
		bits_next = 64'h0;
		seg8_next = 8'h00;
		case (page_o)
			`FPD_PAGE_OPER: begin
				if (legacy_mode_i)
					text_next[63:24] = {`FPD_CH_2, `FPD_CH_SP, `FPD_CH_M, `FPD_CH_O,
						`FPD_CH_D};
				else
					text_next[63:32] = {`FPD_CH_G, `FPD_CH_1, `FPD_CH_2, `FPD_CH_3};
				if (prog_run_i)
					seg8_next = 8'h01 << anim_ph_reg;
				else
					seg8_next = 8'h40;
				// a fault label takes the place of the program string
				if (fault_err_i)
					text_next[63:24] = {`FPD_CH_E, `FPD_CH_R, `FPD_CH_R, `FPD_CH_SP,
						`FPD_CH_SP};
				else if (fault_alarm_i)
					text_next[63:24] = {`FPD_CH_A, `FPD_CH_L, `FPD_CH_M, `FPD_CH_SP,
						`FPD_CH_SP};
				if (fault_err_i || fault_alarm_i)
					text_next[23:8] = hex_pair(fault_code_i);
				if (flash_busy_i && blink_reg)
					text_next[7:0] = `FPD_CH_W;
				if (tool_high_speed_i)
					text_next[31:24] = `FPD_CH_H;
			end
			`FPD_PAGE_ERR: begin
				text_next[63:56] = hex_ch({1'b0, hidx});
				text_next[47:32] = hex_pair(hist_code_mem[hidx]);
				case (sub_view_o)
					2'h1: view_word = hist_det_mem[hidx];
					2'h2: view_word = hist_time_mem[hidx];
					default: view_word = {8'h00, hist_msg_mem[hidx]};
				endcase
				text_next[31:0] = {hex_pair(view_word[15:8]), hex_pair(view_word[7:0])};
			end
			`FPD_PAGE_IO: begin
				case (sub_view_o)
					2'h1: bits_next[31:0] = {io_bits_i[15:0], io_bits_i[31:16]};
					2'h2: bits_next[31:0] = {io_bits_i[47:32], io_bits_i[63:48]};
					default: bits_next = io_bits_i;
				endcase
			end
			`FPD_PAGE_LINK: begin
				// activity glyph toggles with time only, never with link data
				text_next[63:56] = serial_active_i[0] ? (blink_reg ? `FPD_CH_UND :
					`FPD_CH_DASH) : `FPD_CH_SP;
				text_next[55:48] = serial_active_i[1] ? (blink_reg ? `FPD_CH_UND :
					`FPD_CH_DASH) : `FPD_CH_SP;
				text_next[47:40] = serial_active_i[2] ? (blink_reg ? `FPD_CH_UND :
					`FPD_CH_DASH) : `FPD_CH_SP;
				if (sl_code != 8'h00)
					text_next[39:24] = hex_pair(sl_code);
				if (fb_code != 8'h00)
					text_next[23:8] = hex_pair(fb_code);
				else if (fb_active_i)
					text_next[23:8] = hex_pair({2'h0, fb_node_addr_i});
				if (tool_high_speed_i)
					text_next[7:0] = `FPD_CH_H;
			end
			`FPD_PAGE_LIB: begin
				text_next[63:32] = {6'h00, lib_sel_o, lib_id_i, lib_ver_i};
				if (lib_dis != 3'h0) begin
					text_next[31:16] = hex_pair(`FPD_LIB_CALL_ERR);
					text_next[15:8] = hex_ch({1'b0, lib_dis});
				end else if (lib_cap_err) begin
					text_next[31:16] = {`FPD_CH_E, `FPD_CH_L};
				end
			end
			default: text_next = {8{`FPD_CH_SP}};
		endcase
	end

	// registered display outputs
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			text_o <= {8{`FPD_CH_SP}};
			bits_o <= 64'h0;
			seg8_o <= 8'h00;
			lib_glyph_o <= 7'h00;
			lib_err_o <= 1'b0;
			lib_disabled_o <= 3'h0;
		end else begin
			text_o <= text_next;
			bits_o <= bits_next;
			seg8_o <= seg8_next;
			lib_glyph_o <= glyph_next;
			lib_err_o <= (lib_dis != 3'h0) | lib_cap_err;
			lib_disabled_o <= lib_dis;
		end
	end
endmodule // fpd_display

// ### sim/fpd_display_checker.sv
// concurrent checks on the front panel display ports
`timescale 1ns/1ps
`include "fpd_defs.vh"
module fpd_display_checker (
	input wire clk_i,
	input wire rst_n_i,
	input wire mode_btn_i,
	input wire inc_btn_i,
	input wire prog_run_i,
	input wire [2:0] lib_enabled_i,
	input wire [7:0] p2_cap_kw_i,
	input wire [7:0] p3_cap_kw_i,
	input wire [4:0] page_o,
	input wire [1:0] sub_view_o,
	input wire [2:0] hist_sel_o,
	input wire [1:0] lib_sel_o,
	input wire [7:0] seg8_o,
	input wire lib_err_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// successor values of the page and the three-way selectors
	wire [4:0] pg_nx = {page_o[3:0], page_o[4]};
	wire [1:0] sv_nx = (sub_view_o == 2'h2) ? 2'h0 : sub_view_o + 2'h1;
	wire [1:0] ls_nx = (lib_sel_o == 2'h2) ? 2'h0 : lib_sel_o + 2'h1;
	wire cap_err = (p2_cap_kw_i >= 8'h20 && lib_enabled_i[2])
		|| (p3_cap_kw_i >= 8'h20 && lib_enabled_i[1]);
	// one button pressed and held with the other released
	sequence s_inc(pg);
		$rose(inc_btn_i) && !mode_btn_i && page_o == pg ##1 (inc_btn_i && !mode_btn_i) [*2];
	endsequence
	sequence s_mode;
		$rose(mode_btn_i) && !inc_btn_i ##1 (mode_btn_i && !inc_btn_i) [*2];
	endsequence
	a_page_order: assert property ($changed(page_o) |-> page_o == $past(pg_nx))
		else $error("page left the fixed order");
	a_mode_step: assert property (s_mode |-> ##2 page_o == $past(pg_nx, 4))
		else $error("mode press did not advance the page");
	a_one_step: assert property ($changed(page_o) |=> !$changed(page_o) [*2])
		else $error("page stepped twice for one press");
	a_hist_step: assert property (s_inc(`FPD_PAGE_ERR) |-> ##2
		hist_sel_o == $past(hist_sel_o, 4) + 3'h1)
		else $error("history index did not step");
	a_io_rotate: assert property (s_inc(`FPD_PAGE_IO) |-> ##2 sub_view_o == $past(sv_nx, 4))
		else $error("io view did not rotate");
	a_lib_rotate: assert property (s_inc(`FPD_PAGE_LIB) |-> ##2 lib_sel_o == $past(ls_nx, 4))
		else $error("library selector did not rotate");
	a_err_chord: assert property (($rose(mode_btn_i) && inc_btn_i && page_o == `FPD_PAGE_ERR ##1
		(mode_btn_i && inc_btn_i) [*2]) |-> ##2 sub_view_o == $past(sv_nx, 4) && page_o == `FPD_PAGE_ERR)
		else $error("chord did not rotate the error view");
	a_halt_glyph: assert property ((!prog_run_i && page_o == `FPD_PAGE_OPER) [*2]
		|=> seg8_o == 8'h40)
		else $error("halted glyph missing");
	a_lib_cap: assert property (cap_err [*2] |=> lib_err_o)
		else $error("capacity library error missing");
	c_mode: cover property (s_mode);
	c_hist: cover property (s_inc(`FPD_PAGE_ERR));
	c_lib: cover property (s_inc(`FPD_PAGE_LIB));
endmodule // fpd_display_checker
bind fpd_display fpd_display_checker fpd_display_checker_i (.*);

// ### sim/fpd_display_tb_top.sv
// self-checking bench for the front panel display
`timescale 1ns/1ps
`include "fpd_defs.vh"
module fpd_display_tb_top;
	int n_errors = 0;
	int tests_run = 0;
	logic clk_i = '0, rst_n_i = '0, legacy_mode_i = '0, prog_run_i = '0, fault_err_i = '0;
	logic fault_alarm_i = '0, flash_busy_i = '0, hist_we_i = '0, serial_run_fault_i = '0;
	logic serial_start_fault_i = '0, fb_active_i = '0, tool_high_speed_i = '0;
	logic [7:0] fault_code_i = '0, hist_code_i = '0, hist_msg_i = '0, lib_id_i = '0;
	logic [7:0] p2_cap_kw_i = '0, p3_cap_kw_i = '0;
	logic [15:0] hist_detail_i = '0, hist_time_i = '0, lib_ver_i = '0;
	logic [63:0] io_bits_i = 64'h0123456789ABCDEF;
	logic [2:0] serial_active_i = '0, lib_mounted_i = '0, lib_enabled_i = '0, lib_called_i = '0;
	logic [5:0] fb_node_addr_i = '0;
	logic [10:0] fb_fault_i = '0;
	wire mode_btn_i, inc_btn_i, lib_err_o;
	wire [4:0] page_o;
	wire [1:0] sub_view_o, lib_sel_o;
	wire [2:0] hist_sel_o, lib_disabled_o;
	wire [63:0] text_o, bits_o;
	wire [7:0] seg8_o;
	wire [6:0] lib_glyph_o;
	fpd_display #(.ANIM_CYC(4)) fpd_display_i (.*);
	fpd_panel_model fpd_panel_model_i (.clk_i(clk_i), .mode_btn_o(mode_btn_i), .inc_btn_o(inc_btn_i));
	// 125 MHz clock
	initial forever #4 clk_i = ~clk_i;
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// true when the n-character pattern stands anywhere in the text
	function automatic logic has(input logic [63:0] t, input logic [39:0] p, input int n);
		has = 1'b0;
		for (int k = 0; k + n <= 8; k++)
			if (((t >> (8 * k)) & ~({64{1'b1}} << (8 * n))) == p) has = 1'b1;
	endfunction
	function automatic logic [7:0] hc(input logic [3:0] n);
		hc = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
	endfunction
	task automatic push(input logic m, input logic i);
		fpd_panel_model_i.press(m, i);
		step(1);
	endtask
	task automatic go(input logic [4:0] p);
		for (int k = 0; k < 5 && page_o !== p; k++)
			push(1'b1, 1'b0);
		chk(page_o, p);
	endtask
	// five mode presses wrap the pages; a long hold still steps once
	task automatic t_pages;
		logic [4:0] e;
		e = 5'h01;
		chk(page_o, e);
		for (int k = 0; k < 5; k++) begin
			fpd_panel_model_i.hold(1'b1, 1'b0, (k == 2) ? 24 : 4);
			push(1'b0, 1'b0);
			e = {e[3:0], e[4]};
			chk(page_o, e);
		end
	endtask
	// operating page: program tag, run glyph, faults, marks
	task automatic t_oper;
		logic [7:0] s;
		int w;
		w = 0;
		@(posedge clk_i) tool_high_speed_i <= 1'b1;
		step(3);
		chk({has(text_o, 40'h47313233, 4), text_o[31:24], seg8_o}, {1'b1, 8'h48, 8'h40});
		@(posedge clk_i) {tool_high_speed_i, legacy_mode_i, prog_run_i} <= 3'h3;
		step(3);
		s = seg8_o;
		chk(has(text_o, 40'h32204D4F44, 5), 1'b1);
		step(5);
		chk(seg8_o !== s, 1'b1);
		@(posedge clk_i) {fault_alarm_i, fault_code_i} <= 9'h142;
		step(3);
		chk({has(text_o, 40'h414C4D, 3), has(text_o, 40'h3432, 2)}, 2'h3);
		@(posedge clk_i) fault_err_i <= 1'b1;
		step(3);
		chk(has(text_o, 40'h455252, 3), 1'b1);
		@(posedge clk_i) {fault_err_i, fault_alarm_i, flash_busy_i} <= 3'h1;
		for (int k = 0; k < 16; k++) begin
			step(1);
			w += (text_o[7:0] === 8'h57);
		end
		chk(w > 0 && w < 16, 1'b1);
		@(posedge clk_i) flash_busy_i <= 1'b0;
	endtask
	// error page: history stepping and chord view rotation
	task automatic t_err;
		for (int k = 0; k < 8; k++) begin
			@(posedge clk_i) {hist_we_i, hist_code_i, hist_msg_i, hist_detail_i, hist_time_i} <=
				{17'h15A3C, 32'h12345678};
			@(posedge clk_i) hist_we_i <= 1'b0;
		end
		go(5'h02);
		for (int k = 1; k <= 8; k++) begin
			push(1'b0, 1'b1);
			chk({hist_sel_o, has(text_o, 40'h3541, 2), has(text_o, 40'h3343, 2)}, {k[2:0], 2'h3});
			chk(text_o[63:56], 8'h30 + k % 8);
		end
		for (int k = 1; k <= 3; k++) begin
			fpd_panel_model_i.hold(1'b0, 1'b1, 4);
			fpd_panel_model_i.hold(1'b1, 1'b1, 4);
			push(1'b0, 1'b0);
			chk({page_o, sub_view_o}, 7'h08 + k % 3);
			chk(has(text_o, k == 1 ? 40'h31323334 : k == 2 ? 40'h35363738 : 40'h30303343, 4), 1'b1);
		end
	endtask
	// io page: all points, then the two word views
	task automatic t_io;
		logic [63:0] e;
		go(5'h04);
		chk(bits_o, io_bits_i);
		for (int k = 1; k <= 3; k++) begin
			push(1'b0, 1'b1);
			e = io_bits_i >> (32 * (k - 1));
			chk(sub_view_o, k % 3);
			chk(k == 3 ? bits_o : bits_o[31:0], k == 3 ? io_bits_i : {e[15:0], e[31:16]});
		end
	endtask
	// link page: serial link codes and every fieldbus fault code
	task automatic t_link;
		logic [7:0] c [11] = '{8'hD2, 8'hD6, 8'hD9, 8'hE0, 8'hE2, 8'hF0, 8'hF1, 8'hF3, 8'hF6,
			8'hF8, 8'hF9};
		int u = 0;
		go(5'h08);
		@(posedge clk_i) {serial_active_i, serial_run_fault_i, fb_node_addr_i} <= 10'h3EA;
		step(3);
		chk(has(text_o, 40'h3037, 2), 1'b1);
		// the activity glyph must alternate with time while the link is active
		for (int k = 0; k < 8; k++) begin
			step(1);
			u += (text_o[63:56] === 8'h5F);
		end
		chk(u > 0 && u < 8, 1'b1);
		@(posedge clk_i) serial_start_fault_i <= 1'b1;
		step(3);
		chk(has(text_o, 40'h3038, 2), 1'b1);
		@(posedge clk_i) {serial_run_fault_i, serial_start_fault_i, fb_active_i} <= 3'h1;
		for (int k = 0; k < 11; k++) begin
			@(posedge clk_i) fb_fault_i <= 11'h001 << k;
			step(3);
			chk(has(text_o, {hc(c[k][7:4]), hc(c[k][3:0])}, 2), 1'b1);
		end
	endtask
	// library page: selector, mount glyphs, call and capacity errors
	task automatic t_lib;
		logic [6:0] g [8];
		int d;
		d = 0;
		go(5'h10);
		for (int k = 1; k <= 3; k++) begin
			push(1'b0, 1'b1);
			chk(lib_sel_o, k % 3);
		end
		for (int m = 1; m < 8; m++) begin
			@(posedge clk_i) {lib_mounted_i, lib_id_i, lib_ver_i} <= {m[2:0], 24'h5A0200};
			step(3);
			g[m] = lib_glyph_o;
			for (int j = 1; j < m; j++)
				d += (g[j] === g[m]);
		end
		chk(d, 0);
		@(posedge clk_i) {lib_enabled_i, lib_called_i} <= 6'h31;
		step(3);
		chk({has(text_o, 40'h3743, 2), lib_disabled_o}, 4'h9);
		@(posedge clk_i) {lib_enabled_i, lib_called_i, p2_cap_kw_i} <= 14'h2020;
		step(3);
		chk(lib_err_o, 1'b1);
		@(posedge clk_i) {lib_enabled_i, p2_cap_kw_i, p3_cap_kw_i} <= 19'h21F20;
		step(3);
		chk(lib_err_o, 1'b1);
		@(posedge clk_i) p3_cap_kw_i <= 8'h1F;
		step(3);
		chk(lib_err_o, 1'b0);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// main sequence after an 8-cycle reset
	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		step(2);
		t_pages;
		t_oper;
		t_err;
		t_io;
		t_link;
		t_lib;
		conclude;
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge clk_i);
		n_errors++;
		conclude;
	end
endmodule // fpd_display_tb_top

// ### sim/fpd_panel_model.sv
// operator pushbutton model for the front panel
`timescale 1ns/1ps
module fpd_panel_model (
	input wire clk_i,
	output logic mode_btn_o,
	output logic inc_btn_o
);
	// buttons rest released
	initial begin
		mode_btn_o = 1'b0;
		inc_btn_o = 1'b0;
	end
	// hold button levels for n edges, changed just after an edge
	task automatic hold(input logic m, input logic i, input int n);
		@(posedge clk_i);
		mode_btn_o <= m;
		inc_btn_o <= i;
		repeat (n - 1) @(posedge clk_i);
	endtask
	// one press followed by the release gap
	task automatic press(input logic m, input logic i);
		hold(m, i, 4);
		hold(1'b0, 1'b0, 4);
	endtask
endmodule // fpd_panel_model
